// ===== hdl/avcsd_consts.svh
/*
 Offsets, field positions and reset values of the slice command decoder.
 Assumes inclusion by bare name from the package and the testbench modules.
*/
`ifndef AVCSD_CONSTS_SVH
`define AVCSD_CONSTS_SVH
`define ASD_AW 4
`define ASD_DW_LEN 4'h1
`define ASD_DW_ADDR 4'h2
`define ASD_DW_CTRL 4'h3
`define ASD_DW_REFS 4'h4
`define ASD_DW_PRED 4'h5
`define ASD_DW_POS 4'h6
`define ASD_DW_OFFS 4'h7
`define ASD_DW_PKT 4'h0A
`define ASD_DW_VEC 4'h0B
`define ASD_DW_MASK0 4'h0C
`define ASD_DW_MASK3 4'h0F
`define ASD_LEN_MSB 21
`define ASD_ADDR_MSB 28
`define ASD_ENT_POL 10
`define ASD_MBH_POL 8
`define ASD_TYPE_MSB 3
`define ASD_BWD_MSB 29
`define ASD_BWD_LSB 24
`define ASD_FWD_MSB 21
`define ASD_FWD_LSB 16
`define ASD_CSH_MSB 10
`define ASD_CSH_LSB 8
`define ASD_LSH_MSB 2
`define ASD_WM_MSB 31
`define ASD_WM_LSB 30
`define ASD_DIRECT 29
`define ASD_DBK_MSB 28
`define ASD_DBK_LSB 27
`define ASD_CAB_MSB 25
`define ASD_CAB_LSB 24
`define ASD_QP_MSB 21
`define ASD_QP_LSB 16
`define ASD_BETA_MSB 11
`define ASD_BETA_LSB 8
`define ASD_ALPHA_MSB 3
`define ASD_ROW_MSB 31
`define ASD_ROW_LSB 24
`define ASD_COL_MSB 23
`define ASD_COL_LSB 16
`define ASD_LIN_MSB 14
`define ASD_ALTSKIP 7
`define ASD_FBV_MSB 2
`define ASD_PSB_MSB 31
`define ASD_PSB_LSB 29
`define ASD_PCNT_MSB 15
`define ASD_PAGE_LSB 12
`define ASD_WM_EXPLICIT 2'h1
`define ASD_DBK_RSVD 2'h3
`define ASD_ZERO32 32'h00000000
`endif

// ===== hdl/avcsd_pkg.sv
/*
 Types shared by the slice command decoder modules.
 Assumes the constants header is on the include path.
*/
`include "avcsd_consts.svh"
package avcsd_pkg;
	typedef enum logic [1:0] {AVCSD_SEG_P, AVCSD_SEG_B, AVCSD_SEG_I, AVCSD_SEG_RSVD} avcsd_seg_t;
	typedef enum logic [2:0] {AVCSD_WP_OFF, AVCSD_WP_DEFAULT, AVCSD_WP_EXPLICIT, AVCSD_WP_IMPLICIT,
		AVCSD_WP_RSVD} avcsd_wp_t;
	typedef enum logic [1:0] {AVCSD_DBK_ALL, AVCSD_DBK_NONE, AVCSD_DBK_OWN_SLICE, AVCSD_DBK_RSVD} avcsd_dbk_t;
	typedef struct packed {
		logic [21:0] data_length;
		logic [28:0] data_start_addr;
		logic ent_err_policy;
		logic mbh_err_policy;
		logic [3:0] seg_type_code;
		logic [5:0] backward_list_entry_count;
		logic [5:0] forward_list_entry_count;
		logic [2:0] chroma_weight_shift;
		logic [2:0] luma_weight_shift;
		logic [1:0] weight_code;
		logic direct_spatial;
		logic [1:0] deblock_code;
		logic [1:0] ctx_init_index;
		logic [5:0] segment_quantizer;
		logic [3:0] filter_beta_adjust;
		logic [3:0] filter_alpha_adjust;
		logic [7:0] first_block_row;
		logic [7:0] first_block_column;
		logic [14:0] first_block_linear_index;
		logic alt_skip_decode_enable;
		logic [2:0] first_byte_valid_bits_m1;
		logic [2:0] pkt_vec_start_bit;
		logic [15:0] pkt_total_count;
		logic [16:0] pkt_vec_page;
	} avcsd_par_t;
endpackage : avcsd_pkg

// ===== hdl/avcsd_mask_mem.sv
/*
 Four-word store for the unity-weight masks, two registered read ports.
 Assumes one writer and single-clock use.
*/
`timescale 1ns/1ps
module avcsd_mask_mem #(
	parameter int WORDS = 4,
	parameter int WIDTH = 32
) (
	input wire logic clk_sys, // core clock
	input wire logic sys_rst, // async reset, high
	input wire logic wr_en, // write strobe
	input wire logic [$clog2(WORDS)-1:0] wr_addr, // write word
	input wire logic [WIDTH-1:0] wr_data, // write data
	input wire logic [$clog2(WORDS)-1:0] ra_addr, // port A word
	output logic [WIDTH-1:0] ra_data_q, // port A data
	input wire logic [$clog2(WORDS)-1:0] rb_addr, // port B word
	output logic [WIDTH-1:0] rb_data_q // port B data
);
	logic [WIDTH-1:0] mem_q [WORDS];
	genvar gi;
	generate
		for (gi = 0; gi < WORDS; gi++) begin : g_word
			always_ff @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst)
					mem_q[gi] <= '0;
				else if (wr_en && wr_addr == ($clog2(WORDS))'(gi))
					mem_q[gi] <= wr_data;
			end
		end
	endgenerate
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ra_data_q <= '0;
			rb_data_q <= '0;
		end else begin
			ra_data_q <= mem_q[ra_addr];
			rb_data_q <= mem_q[rb_addr];
		end
	end
endmodule : avcsd_mask_mem

// ===== hdl/avcsd_decoder.sv
/*
 Slice decode command parameter decoder: latches inline dwords, decodes modes,
 applies error policy, gates weight tables, walks the packet bit vector and
 bounds the slice byte stream.
 Assumes the command streamer writes dwords by index on the plain port and the
 entropy datapath shares clk_sys.
*/
// Behaviour
// - Entropy error: interrupt if policy bit set, else silent auto handling.
// - Header error: interrupt if policy bit set, else concealment and continue.
// - Segment type codes 0 P, 1 B, 2 I; others reserved.
// - Chroma and luma weight shifts from bits 10:8 and 2:0.
// - B slice weighting: 00 default, 01 explicit, 10 implicit, 11 illegal.
// - P slice weighting: 00 off, 01 explicit, 10 and 11 reserved.
// - Weight tables kept only under explicit weighting, otherwise read and dropped.
// - Bit 29 chooses temporal or spatial direct for B; else zero (bit 29 is latched as written for every segment type).
// - Deblocking field: all edges, none, own slice only, reserved.
// - Context table index from 25:24, quantizer from 21:16.
// - Filter offsets are signed four-bit values within -6..+6.
// - First-byte offset is valid bit count minus one.
// - Bit 7 of dword 7 enables alternative skip decoding.
// - Packet start bit from 31:29, total packet count from 15:0.
// - Bit vector on 4K page; bit 0 fetch, bit 1 skip.
// - Start at given byte and bit; ignore bytes after last non-zero.
// - Parameters hold until reset or the next command rewrites them.
`timescale 1ns/1ps
module avcsd_decoder
	import avcsd_pkg::*;
(
	input wire logic clk_sys, // 10 MHz core clock
	input wire logic sys_rst, // async reset, high
	input wire logic [`ASD_AW-1:0] cmd_addr, // dword index
	input wire logic [31:0] cmd_wdata, // dword value
	input wire logic cmd_wr, // write strobe
	input wire logic cmd_rd, // read strobe
	output logic [31:0] cmd_rdata_q, // read data, cycle after strobe
	output logic cmd_done_q, // last dword taken, pulse
	output avcsd_par_t par_q, // latched slice parameters
	output avcsd_seg_t seg_kind_q, // decoded segment type
	output avcsd_wp_t weight_mode_q, // decoded weighting
	output avcsd_dbk_t deblock_mode_q, // decoded deblocking
	input wire logic ent_err, // entropy error pulse
	input wire logic mbh_err, // header error pulse
	output logic ent_irq_q, // entropy error interrupt pulse
	output logic mbh_irq_q, // header error interrupt pulse
	output logic auto_handle_q, // silent entropy handling pulse
	output logic conceal_q, // concealment request pulse
	input wire logic tbl_valid, // weight table word offered
	output logic tbl_keep_q, // table word kept, pulse
	output logic tbl_drop_q, // table word dropped, pulse
	input wire logic vec_valid, // packet bit offered
	input wire logic vec_bit, // packet bit value
	output logic pkt_fetch_q, // fetch packet pulse
	output logic pkt_skip_q, // skip packet pulse
	output logic pkt_done_q, // all packets walked
	input wire logic byte_valid, // slice byte offered
	input wire logic [7:0] byte_data, // slice byte
	output logic byte_pass_q, // byte inside length, pulse
	output logic [21:0] last_nz_q, // index of last non-zero byte
	output logic [31:0] start_bit_q, // first bit address
	input wire logic [1:0] mask_sel, // 0 luma fwd .. 3 chroma bwd
	output logic [31:0] mask_word_q // selected unity-weight mask
);
	logic wr_mask;
	logic [31:0] mem_bus_q;
	logic rd_mask_q;
	logic [`ASD_AW-1:0] rd_addr_q;
	logic rd_q;
	logic [21:0] byte_idx_q;
	logic [15:0] pkt_idx_q;
	logic explicit_w;

	assign wr_mask = cmd_wr && cmd_addr >= `ASD_DW_MASK0;
	assign explicit_w = weight_mode_q == AVCSD_WP_EXPLICIT;

	avcsd_mask_mem #(.WORDS(4), .WIDTH(32)) avcsd_mask_mem_i (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.wr_en(wr_mask),
		.wr_addr(cmd_addr[1:0]),
		.wr_data(cmd_wdata),
		.ra_addr(cmd_addr[1:0]),
		.ra_data_q(mem_bus_q),
		.rb_addr(mask_sel),
		.rb_data_q(mask_word_q)
	);

	// Fields land directly; only defined bits are stored so reserved bits cannot leak
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			par_q <= '0;
		end else if (cmd_wr) begin
			case (cmd_addr)
				`ASD_DW_LEN: par_q.data_length <= cmd_wdata[`ASD_LEN_MSB:0];
				`ASD_DW_ADDR: par_q.data_start_addr <= cmd_wdata[`ASD_ADDR_MSB:0];
				`ASD_DW_CTRL: begin
					par_q.ent_err_policy <= cmd_wdata[`ASD_ENT_POL];
					par_q.mbh_err_policy <= cmd_wdata[`ASD_MBH_POL];
					par_q.seg_type_code <= cmd_wdata[`ASD_TYPE_MSB:0];
				end
				`ASD_DW_REFS: begin
					par_q.backward_list_entry_count <= cmd_wdata[`ASD_BWD_MSB:`ASD_BWD_LSB];
					par_q.forward_list_entry_count <= cmd_wdata[`ASD_FWD_MSB:`ASD_FWD_LSB];
					par_q.chroma_weight_shift <= cmd_wdata[`ASD_CSH_MSB:`ASD_CSH_LSB];
					par_q.luma_weight_shift <= cmd_wdata[`ASD_LSH_MSB:0];
				end
				`ASD_DW_PRED: begin
					par_q.weight_code <= cmd_wdata[`ASD_WM_MSB:`ASD_WM_LSB];
					par_q.direct_spatial <= cmd_wdata[`ASD_DIRECT];
					par_q.deblock_code <= cmd_wdata[`ASD_DBK_MSB:`ASD_DBK_LSB];
					par_q.ctx_init_index <= cmd_wdata[`ASD_CAB_MSB:`ASD_CAB_LSB];
					par_q.segment_quantizer <= cmd_wdata[`ASD_QP_MSB:`ASD_QP_LSB];
					par_q.filter_beta_adjust <= cmd_wdata[`ASD_BETA_MSB:`ASD_BETA_LSB];
					par_q.filter_alpha_adjust <= cmd_wdata[`ASD_ALPHA_MSB:0];
				end
				`ASD_DW_POS: begin
					par_q.first_block_row <= cmd_wdata[`ASD_ROW_MSB:`ASD_ROW_LSB];
					par_q.first_block_column <= cmd_wdata[`ASD_COL_MSB:`ASD_COL_LSB];
					par_q.first_block_linear_index <= cmd_wdata[`ASD_LIN_MSB:0];
				end
				`ASD_DW_OFFS: begin
					par_q.alt_skip_decode_enable <= cmd_wdata[`ASD_ALTSKIP];
					par_q.first_byte_valid_bits_m1 <= cmd_wdata[`ASD_FBV_MSB:0];
				end
				`ASD_DW_PKT: begin
					par_q.pkt_vec_start_bit <= cmd_wdata[`ASD_PSB_MSB:`ASD_PSB_LSB];
					par_q.pkt_total_count <= cmd_wdata[`ASD_PCNT_MSB:0];
				end
				// Low address bits dropped: the vector sits on a 4K page
				`ASD_DW_VEC: par_q.pkt_vec_page <= cmd_wdata[`ASD_ADDR_MSB:`ASD_PAGE_LSB];
				default: par_q <= par_q;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			cmd_done_q <= 1'b0;
		else
			cmd_done_q <= cmd_wr && cmd_addr == `ASD_DW_MASK3;
	end

	// Decoded modes follow the latched fields one cycle later
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			seg_kind_q <= AVCSD_SEG_P;
			weight_mode_q <= AVCSD_WP_OFF;
			deblock_mode_q <= AVCSD_DBK_ALL;
		end else begin
			case (par_q.seg_type_code)
				4'h0: seg_kind_q <= AVCSD_SEG_P;
				4'h1: seg_kind_q <= AVCSD_SEG_B;
				4'h2: seg_kind_q <= AVCSD_SEG_I;
				default: seg_kind_q <= AVCSD_SEG_RSVD;
			endcase
			case ({par_q.seg_type_code, par_q.weight_code})
				6'h00: weight_mode_q <= AVCSD_WP_OFF;
				6'h01: weight_mode_q <= AVCSD_WP_EXPLICIT;
				6'h04: weight_mode_q <= AVCSD_WP_DEFAULT;
				6'h05: weight_mode_q <= AVCSD_WP_EXPLICIT;
				6'h06: weight_mode_q <= AVCSD_WP_IMPLICIT;
				6'h08, 6'h09, 6'h0A, 6'h0B: weight_mode_q <= AVCSD_WP_OFF;
				default: weight_mode_q <= AVCSD_WP_RSVD;
			endcase
			case (par_q.deblock_code)
				2'h0: deblock_mode_q <= AVCSD_DBK_ALL;
				2'h1: deblock_mode_q <= AVCSD_DBK_NONE;
				2'h2: deblock_mode_q <= AVCSD_DBK_OWN_SLICE;
				default: deblock_mode_q <= AVCSD_DBK_RSVD;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ent_irq_q <= 1'b0;
			auto_handle_q <= 1'b0;
			mbh_irq_q <= 1'b0;
			conceal_q <= 1'b0;
		end else begin
			ent_irq_q <= ent_err && par_q.ent_err_policy;
			auto_handle_q <= ent_err && !par_q.ent_err_policy;
			mbh_irq_q <= mbh_err && par_q.mbh_err_policy;
			conceal_q <= mbh_err && !par_q.mbh_err_policy;
		end
	end

	// Tables outside explicit weighting are still consumed, never applied
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			tbl_keep_q <= 1'b0;
			tbl_drop_q <= 1'b0;
		end else begin
			tbl_keep_q <= tbl_valid && explicit_w;
			tbl_drop_q <= tbl_valid && !explicit_w;
		end
	end

	// Packet walk restarts whenever a new total count is written
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pkt_idx_q <= '0;
			pkt_fetch_q <= 1'b0;
			pkt_skip_q <= 1'b0;
			pkt_done_q <= 1'b0;
		end else begin
			pkt_fetch_q <= vec_valid && !pkt_done_q && !vec_bit;
			pkt_skip_q <= vec_valid && !pkt_done_q && vec_bit;
			if (cmd_wr && cmd_addr == `ASD_DW_PKT) begin
				pkt_idx_q <= '0;
				pkt_done_q <= 1'b0;
			end else if (vec_valid && !pkt_done_q) begin
				pkt_idx_q <= pkt_idx_q + 16'h0001;
				pkt_done_q <= pkt_idx_q + 16'h0001 >= par_q.pkt_total_count;
			end
		end
	end

	// Trailing zero bytes are decided afterwards from last_nz_q, no look-ahead buffer
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			byte_idx_q <= '0;
			byte_pass_q <= 1'b0;
			last_nz_q <= '0;
		end else if (cmd_wr && cmd_addr == `ASD_DW_LEN) begin
			byte_idx_q <= '0;
			byte_pass_q <= 1'b0;
			last_nz_q <= '0;
		end else begin
			byte_pass_q <= byte_valid && byte_idx_q < par_q.data_length;
			if (byte_valid)
				byte_idx_q <= byte_idx_q + 22'h000001;
			if (byte_valid && byte_idx_q < par_q.data_length && byte_data != 8'h00)
				last_nz_q <= byte_idx_q;
		end
	end

	// MSB-first bytes: first valid bit sits at position m1 of the first byte
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			start_bit_q <= '0;
		else
			start_bit_q <= {par_q.data_start_addr, 3'h7 - par_q.first_byte_valid_bits_m1};
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rd_q <= 1'b0;
			rd_addr_q <= '0;
		end else begin
			rd_q <= cmd_rd;
			rd_addr_q <= cmd_addr;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_rdata_q <= `ASD_ZERO32;
			rd_mask_q <= 1'b0;
		end else begin
			rd_mask_q <= cmd_rd && cmd_addr >= `ASD_DW_MASK0;
			cmd_rdata_q <= `ASD_ZERO32;
			if (cmd_rd) begin
				case (cmd_addr)
					`ASD_DW_LEN: cmd_rdata_q <= {10'h000, par_q.data_length};
					`ASD_DW_ADDR: cmd_rdata_q <= {3'h0, par_q.data_start_addr};
					`ASD_DW_CTRL: cmd_rdata_q <= {21'h000000, par_q.ent_err_policy, 1'b0,
						par_q.mbh_err_policy, 4'h0, par_q.seg_type_code};
					`ASD_DW_REFS: cmd_rdata_q <= {2'h0, par_q.backward_list_entry_count, 2'h0,
						par_q.forward_list_entry_count, 5'h00, par_q.chroma_weight_shift, 5'h00,
						par_q.luma_weight_shift};
					`ASD_DW_PRED: cmd_rdata_q <= {par_q.weight_code, par_q.direct_spatial, par_q.deblock_code,
						1'b0, par_q.ctx_init_index, 2'h0, par_q.segment_quantizer, 4'h0,
						par_q.filter_beta_adjust, 4'h0, par_q.filter_alpha_adjust};
					`ASD_DW_POS: cmd_rdata_q <= {par_q.first_block_row, par_q.first_block_column, 1'b0,
						par_q.first_block_linear_index};
					`ASD_DW_OFFS: cmd_rdata_q <= {24'h000000, par_q.alt_skip_decode_enable, 4'h0,
						par_q.first_byte_valid_bits_m1};
					`ASD_DW_PKT: cmd_rdata_q <= {par_q.pkt_vec_start_bit, 13'h0000, par_q.pkt_total_count};
					`ASD_DW_VEC: cmd_rdata_q <= {3'h0, par_q.pkt_vec_page, 12'h000};
					default: cmd_rdata_q <= `ASD_ZERO32;
				endcase
			end
		end
	end

	// Mask words come out of the store one cycle late; rd_mask_q aligns them
	logic [31:0] bus_view;
	assign bus_view = rd_mask_q ? mem_bus_q : cmd_rdata_q;

	property p_ent_irq;
		@(posedge clk_sys) disable iff (sys_rst) ent_err && par_q.ent_err_policy |=> ent_irq_q && !auto_handle_q;
	endproperty
	a_ent_irq: assert property (p_ent_irq) else $error("entropy interrupt missing");
	property p_mbh;
		@(posedge clk_sys) disable iff (sys_rst) mbh_err |=> (conceal_q != mbh_irq_q) && (mbh_irq_q == $past(par_q.mbh_err_policy));
	endproperty
	a_mbh: assert property (p_mbh) else $error("header error policy wrong");
	property p_seg;
		@(posedge clk_sys) disable iff (sys_rst)
			cmd_wr && cmd_addr == `ASD_DW_CTRL && cmd_wdata[`ASD_TYPE_MSB:0] == 4'h1 ##1 !cmd_wr |=> seg_kind_q == AVCSD_SEG_B;
	endproperty
	a_seg: assert property (p_seg) else $error("segment type decode wrong");
	property p_wp;
		@(posedge clk_sys) disable iff (sys_rst) par_q.seg_type_code == 4'h0 && par_q.weight_code[1] |=> weight_mode_q == AVCSD_WP_RSVD;
	endproperty
	a_wp: assert property (p_wp) else $error("reserved P weighting accepted");
	property p_tbl;
		@(posedge clk_sys) disable iff (sys_rst) tbl_valid && weight_mode_q != AVCSD_WP_EXPLICIT |=> tbl_drop_q && !tbl_keep_q;
	endproperty
	a_tbl: assert property (p_tbl) else $error("table kept outside explicit mode");
	property p_pkt;
		@(posedge clk_sys) disable iff (sys_rst) vec_valid && vec_bit && !pkt_done_q |=> pkt_skip_q && !pkt_fetch_q;
	endproperty
	a_pkt: assert property (p_pkt) else $error("flagged packet fetched");
	property p_hold;
		@(posedge clk_sys) disable iff (sys_rst) !cmd_wr [*2] |-> $stable(par_q);
	endproperty
	a_hold: assert property (p_hold) else $error("parameters changed without a write");
	property p_rsvd;
		@(posedge clk_sys) disable iff (sys_rst)
			rd_q && rd_addr_q == `ASD_DW_CTRL |-> bus_view[31:11] == 21'h000000 && bus_view[7:4] == 4'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
	property p_pass;
		@(posedge clk_sys) disable iff (sys_rst) byte_valid && byte_idx_q >= par_q.data_length && !cmd_wr |=> !byte_pass_q;
	endproperty
	a_pass: assert property (p_pass) else $error("byte beyond length passed");

	c_irq: cover property (@(posedge clk_sys) ent_irq_q);
	c_conceal: cover property (@(posedge clk_sys) conceal_q);
	c_keep: cover property (@(posedge clk_sys) tbl_keep_q);
	c_done: cover property (@(posedge clk_sys) pkt_done_q ##1 cmd_done_q);
endmodule : avcsd_decoder

// ===== testbench/avcsd_streamer.sv
/*
 Command streamer model: issues the dwords of a slice decode command.
 Assumes the decoder never stalls and answers reads one cycle later.
*/
`timescale 1ns/1ps
`include "avcsd_consts.svh"
module avcsd_streamer (
	input wire logic clk_sys, // core clock
	output logic [`ASD_AW-1:0] cmd_addr, // dword index
	output logic [31:0] cmd_wdata, // dword value
	output logic cmd_wr, // write strobe
	output logic cmd_rd, // read strobe
	input wire logic [31:0] cmd_rdata_q // read data
);
	initial begin
		cmd_addr = '0;
		cmd_wdata = '0;
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
	end
	// One strobe cycle; data bus inverted afterwards so no stale value lingers
	task automatic wr(input logic [`ASD_AW-1:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		cmd_wr <= 1'b1;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge clk_sys);
		cmd_wr <= 1'b0;
		cmd_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [`ASD_AW-1:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		cmd_rd <= 1'b1;
		cmd_addr <= a;
		@(posedge clk_sys);
		cmd_rd <= 1'b0;
		#1;
		d = cmd_rdata_q;
	endtask : rd
endmodule : avcsd_streamer

// ===== testbench/avc_slice_command_decoder_tb.sv
/*
 Self-checking bench for the slice command decoder.
 Assumes the streamer model drives the command port; the bench plays the datapath.
*/
`timescale 1ns/1ps
`include "avcsd_consts.svh"
module avc_slice_command_decoder_tb;
	import avcsd_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [`ASD_AW-1:0] cmd_addr;
	logic [31:0] cmd_wdata, cmd_rdata_q, start_bit_q, mask_word_q, rdv;
	logic cmd_wr, cmd_rd, cmd_done_q, ent_irq_q, mbh_irq_q, auto_handle_q, conceal_q;
	logic ent_err = 1'b0, mbh_err = 1'b0, tbl_valid = 1'b0, vec_valid = 1'b0, vec_bit = 1'b0;
	logic byte_valid = 1'b0, tbl_keep_q, tbl_drop_q, pkt_fetch_q, pkt_skip_q, pkt_done_q, byte_pass_q;
	logic [7:0] byte_data = 8'h00;
	logic [1:0] mask_sel = 2'h0;
	logic [21:0] last_nz_q;
	avcsd_par_t par_q;
	avcsd_seg_t seg_kind_q;
	avcsd_wp_t weight_mode_q, wexp;
	avcsd_dbk_t deblock_mode_q;
	int error_cnt = 0, checks = 0;
	always #50 clk_sys = ~clk_sys;
	avcsd_streamer avcsd_streamer_i (.clk_sys(clk_sys), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata_q(cmd_rdata_q));
	avcsd_decoder avcsd_decoder_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata_q(cmd_rdata_q),
		.cmd_done_q(cmd_done_q), .par_q(par_q), .seg_kind_q(seg_kind_q), .weight_mode_q(weight_mode_q),
		.deblock_mode_q(deblock_mode_q), .ent_err(ent_err), .mbh_err(mbh_err), .ent_irq_q(ent_irq_q),
		.mbh_irq_q(mbh_irq_q), .auto_handle_q(auto_handle_q), .conceal_q(conceal_q),
		.tbl_valid(tbl_valid), .tbl_keep_q(tbl_keep_q), .tbl_drop_q(tbl_drop_q), .vec_valid(vec_valid),
		.vec_bit(vec_bit), .pkt_fetch_q(pkt_fetch_q), .pkt_skip_q(pkt_skip_q), .pkt_done_q(pkt_done_q),
		.byte_valid(byte_valid), .byte_data(byte_data), .byte_pass_q(byte_pass_q),
		.last_nz_q(last_nz_q), .start_bit_q(start_bit_q), .mask_sel(mask_sel), .mask_word_q(mask_word_q));
	task automatic end_of_test;
		if (error_cnt == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [199:0] got, input logic [199:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : idle
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		avcsd_streamer_i.wr(a, d);
		idle(2);
	endtask : wr
	// Kind 0 both errors, 1 table word, 2 packet bit, 3 slice byte
	task automatic pulse(input int k, input logic [7:0] d);
		@(posedge clk_sys);
		case (k)
			0: begin ent_err <= 1'b1; mbh_err <= 1'b1; end
			1: tbl_valid <= 1'b1;
			2: begin vec_valid <= 1'b1; vec_bit <= d[0]; end
			default: begin byte_valid <= 1'b1; byte_data <= d; end
		endcase
		@(posedge clk_sys);
		{ent_err, mbh_err, tbl_valid, vec_valid, byte_valid} <= 5'h00;
		byte_data <= ~d;
		#1;
	endtask : pulse
	function automatic avcsd_wp_t exp_wp(input int s, input int w);
		if (s == 2)
			return AVCSD_WP_OFF;
		if (s == 1)
			return w == 0 ? AVCSD_WP_DEFAULT : w == 1 ? AVCSD_WP_EXPLICIT : w == 2 ? AVCSD_WP_IMPLICIT : AVCSD_WP_RSVD;
		return w == 0 ? AVCSD_WP_OFF : w == 1 ? AVCSD_WP_EXPLICIT : AVCSD_WP_RSVD;
	endfunction : exp_wp
	initial begin
		#(5000 * 100);
		error_cnt++;
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1;
		chk(par_q, '0);
		chk(weight_mode_q, AVCSD_WP_OFF);
		for (int p = 0; p < 4; p++) begin
			wr(`ASD_DW_CTRL, {21'h0, p[1], 1'b0, p[0], 8'hF1});
			pulse(0, 8'h00);
			chk({ent_irq_q, auto_handle_q}, {p[1], ~p[1]});
			chk({mbh_irq_q, conceal_q}, {p[0], ~p[0]});
		end
		for (int s = 0; s < 4; s++) begin
			wr(`ASD_DW_CTRL, 32'h0000_00F0 | s);
			chk(par_q.seg_type_code, s);
			chk(seg_kind_q, avcsd_seg_t'(s));
		end
		wr(`ASD_DW_REFS, 32'hE0E0_FFFD);
		chk({par_q.backward_list_entry_count, par_q.forward_list_entry_count}, 12'h820);
		chk({par_q.chroma_weight_shift, par_q.luma_weight_shift}, 6'h3D);
		avcsd_streamer_i.rd(`ASD_DW_REFS, rdv);
		chk(rdv, 32'h2020_0705);
		for (int s = 0; s < 3; s++) begin
			wr(`ASD_DW_CTRL, s);
			for (int i = 0; i < 4; i++) begin
				wr(`ASD_DW_PRED, (i << 30) | ((s == 1 && i[0]) << 29) | (i << 27) | 32'h04C0_F6FA | (i << 24)
					| ((10 + i) << 16));
				wexp = exp_wp(s, i);
				chk(weight_mode_q, wexp);
				chk(par_q.direct_spatial, s == 1 && i[0]);
				chk(deblock_mode_q, avcsd_dbk_t'(i));
				chk({par_q.ctx_init_index, par_q.segment_quantizer}, {i[1:0], 6'(10 + i)});
				chk({par_q.filter_beta_adjust, par_q.filter_alpha_adjust}, 8'h6A);
				pulse(1, 8'h00);
				chk({tbl_keep_q, tbl_drop_q}, {wexp == AVCSD_WP_EXPLICIT, wexp != AVCSD_WP_EXPLICIT});
			end
		end
		wr(`ASD_DW_POS, 32'h0305_807D);
		chk({par_q.first_block_row, par_q.first_block_column, par_q.first_block_linear_index},
			{8'h03, 8'h05, 15'h007D});
		wr(`ASD_DW_POS, 32'h0000_0F01);
		chk(par_q.first_block_linear_index, 15'h0F01);
		wr(`ASD_DW_ADDR, 32'hE000_1234);
		for (int k = 0; k < 2; k++) begin
			wr(`ASD_DW_OFFS, 32'hFFFF_FF78 | (k << 7) | (k ? 32'h7 : 32'h0));
			chk({par_q.alt_skip_decode_enable, par_q.first_byte_valid_bits_m1}, k ? 4'hF : 4'h0);
			chk(start_bit_q, {29'h0000_1234, k ? 3'h0 : 3'h7});
		end
		wr(`ASD_DW_PKT, 32'hBFFF_0003);
		chk({par_q.pkt_vec_start_bit, par_q.pkt_total_count}, 19'h5_0003);
		wr(`ASD_DW_VEC, 32'hE0AB_CFFF);
		chk(par_q.pkt_vec_page, 17'h00ABC);
		for (int b = 0; b < 4; b++) begin
			pulse(2, 8'(b == 1));
			chk({pkt_fetch_q, pkt_skip_q}, b == 3 ? 2'h0 : b == 1 ? 2'h1 : 2'h2);
		end
		chk(pkt_done_q, 1'b1);
		wr(`ASD_DW_PKT, 32'hBFFF_0003);
		chk(pkt_done_q, 1'b0);
		wr(`ASD_DW_LEN, 32'hFFC0_0004);
		for (int b = 0; b < 6; b++) begin
			pulse(3, b[0] ? 8'h00 : 8'h11 * (b + 1));
			chk(byte_pass_q, b < 4);
		end
		chk(last_nz_q, 22'h2);
		for (int k = 0; k < 4; k++)
			avcsd_streamer_i.wr(`ASD_DW_MASK0 + k, 32'h8000_0001 + k * 32'h11);
		#1;
		chk(cmd_done_q, 1'b1);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys);
			mask_sel <= k;
			idle(1);
			chk(mask_word_q, 32'h8000_0001 + k * 32'h11);
		end
		wr(4'h8, 32'hFFFF_FFFF);
		wr(4'h0, 32'hFFFF_FFFF);
		chk(par_q.data_length, 22'h4);
		avcsd_streamer_i.rd(4'h0, rdv);
		chk(rdv, 32'h0);
		avcsd_streamer_i.rd(`ASD_DW_MASK0, rdv);
		chk(rdv, 32'h0);
		avcsd_streamer_i.rd(`ASD_DW_CTRL, rdv);
		chk(rdv, 32'h0000_0002);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		idle(2);
		chk(par_q, '0);
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		idle(2);
		chk(seg_kind_q, AVCSD_SEG_P);
		end_of_test();
	end
endmodule : avc_slice_command_decoder_tb
